// ---- hdl/irq_regs_pkg.sv ----
// Constants, register map and carrier types of the enable/priority slice.
// Assumes a 32-bit Avalon-MM slave with word addressing.
package irq_regs_pkg;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int ADDR_W = 4;
   localparam int PRIO_W = 3;
   localparam int NUM_PRIO_SRC = 7;
   localparam int NUM_EN_SRC = 12;
   localparam int NUM_SRC = NUM_PRIO_SRC + NUM_EN_SRC;

   // Word index; byte address is four times the index
   localparam logic [ADDR_W-1:0] OFS_EN2 = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_EN3 = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_EN4 = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_EN5 = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_PRIO0 = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_PRIO1 = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_FLAG = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h7;

   // Implemented bits; all others read zero and ignore writes
   localparam logic [DATA_W-1:0] EN2_IMPL = 32'h00000023;
   localparam logic [DATA_W-1:0] EN3_IMPL = 32'h00004006;
   localparam logic [DATA_W-1:0] EN4_IMPL = 32'h0000210E;
   localparam logic [DATA_W-1:0] EN5_IMPL = 32'h00000001;
   localparam logic [DATA_W-1:0] PRIO0_IMPL = 32'h00007777;
   localparam logic [DATA_W-1:0] PRIO1_IMPL = 32'h00007770;
   localparam logic [DATA_W-1:0] SRC_IMPL = 32'h0007FFFF;

   // Reset values
   localparam logic [REG_W-1:0] EN_RST = 16'h0000;
   localparam logic [REG_W-1:0] PRIO0_RST = 16'h4444;
   localparam logic [REG_W-1:0] PRIO1_RST = 16'h4440;
   localparam logic [NUM_SRC-1:0] SRC_RST = 19'h00000;

   // Enable bit positions
   localparam int CAP3_EN_BIT = 5;
   localparam int SPI2_EVT_EN_BIT = 1;
   localparam int SPI2_FLT_EN_BIT = 0;
   localparam int CAL_EN_BIT = 14;
   localparam int TW2_MST_EN_BIT = 2;
   localparam int TW2_SLV_EN_BIT = 1;
   localparam int CTIME_EN_BIT = 13;
   localparam int VDET_EN_BIT = 8;
   localparam int CRC_EN_BIT = 3;
   localparam int SER2_ERR_EN_BIT = 2;
   localparam int SER1_ERR_EN_BIT = 1;
   localparam int WAKE_EN_BIT = 0;

   // Priority field low bits
   localparam int EXT_PRIO_LSB = 0;
   localparam int CAPTURE_PRIO_LSB = 4;
   localparam int COMPARE_PRIO_LSB = 8;
   localparam int TIMER_PRIO_LSB = 12;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK = 2'b10
   } bus_state_t;

   typedef struct packed {
      logic valid;
      logic [PRIO_W-1:0] level;
   } fwd_t;

   typedef fwd_t [NUM_SRC-1:0] fwd_vec_t;
   typedef logic [NUM_SRC-1:0] src_vec_t;
   typedef logic [NUM_PRIO_SRC-1:0] low_en_t;
   typedef logic [NUM_EN_SRC-1:0][PRIO_W-1:0] ext_prio_t;
endpackage

// ---- hdl/interrupt_enable_priority_regs.sv ----
// Enable registers two to five, priority registers zero and one, request
// flags, flag mask and forwarding of ranked requests.
// Assumes request inputs and external enables/priorities are on sys_clk.
// Function
// - An enable bit of one passes its source's request to fwdOut, zero blocks it; irq ignores enables.
// - Unimplemented bits of enable and priority registers read zero.
// - Priority fields are three bits; code 111 is level 7, highest.
// - Code 001 is level 1, lowest; other codes map to equal levels.
// - Code 000 keeps the source off fwdOut whatever its enable and flag hold.
// - Reset clears all enables and sets every priority field to 100.
// - Enable two: capture three bit 5, serial two event 1, fault 0.
// - Enable three: calendar bit 14, two-wire master 2, slave 1.
// - Enable four: charge 13, voltage 8, checksum 3, serial errors 2,1.
// - Enable five holds only the low-power wake enable at bit 0.
// - Priority zero: timer one, compare one, capture one, external zero.
// - Priority one: timer two, compare two, capture two; bits 3-0 zero.
// - Each source has a flag set by hardware when its request occurs.
`timescale 1ns/1ns
module interrupt_enable_priority_regs (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [irq_regs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [irq_regs_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [irq_regs_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Peripheral requests
   input wire irq_regs_pkg::src_vec_t srcReq,
   // Enables and priorities held outside this slice
   input wire irq_regs_pkg::low_en_t lowEnable,
   input wire irq_regs_pkg::ext_prio_t extPrio,
   // Ranked requests toward arbitration
   output irq_regs_pkg::fwd_vec_t fwdOut,
   // Summary interrupt
   output logic irq
);
   import irq_regs_pkg::*;

   function automatic logic [DATA_W-1:0] wrWord(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] data,
      input logic [3:0] be,
      input logic [DATA_W-1:0] impl);
      logic [DATA_W-1:0] wm;
      wm = impl & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      wrWord = (old & ~wm) | (data & wm);
   endfunction

   function automatic logic [PRIO_W-1:0] field(
      input logic [REG_W-1:0] r,
      input int lsb);
      field = r[lsb +: PRIO_W];
   endfunction

   bus_state_t state, next_state;
   logic next_waitReq;
   logic [DATA_W-1:0] next_readData;
   logic [REG_W-1:0] en2, en3, en4, en5, prio0, prio1;
   logic [REG_W-1:0] next_en2, next_en3, next_en4, next_en5;
   logic [REG_W-1:0] next_prio0, next_prio1;
   src_vec_t flags, mask, captured;
   src_vec_t next_flags, next_mask, next_captured, clrBits;
   logic [DATA_W-1:0] readValue;
   fwd_vec_t next_fwd;
   logic next_irq;
   src_vec_t srcEnable;
   logic [NUM_SRC-1:0][PRIO_W-1:0] srcPrio;

   // Read view; unimplemented bits are never stored, so they read zero
   always_comb begin
      unique case (avs_address)
         OFS_EN2: readValue = {16'h0000, en2};
         OFS_EN3: readValue = {16'h0000, en3};
         OFS_EN4: readValue = {16'h0000, en4};
         OFS_EN5: readValue = {16'h0000, en5};
         OFS_PRIO0: readValue = {16'h0000, prio0};
         OFS_PRIO1: readValue = {16'h0000, prio1};
         OFS_FLAG: readValue = {13'h0000, flags};
         OFS_MASK: readValue = {13'h0000, mask};
         default: readValue = 32'h00000000;
      endcase
   end

   // Bus handshake and register updates
   always_comb begin
      next_state = state;
      next_waitReq = 1'b1;
      next_readData = avs_readdata;
      next_captured = captured;
      next_en2 = en2;
      next_en3 = en3;
      next_en4 = en4;
      next_en5 = en5;
      next_prio0 = prio0;
      next_prio1 = prio1;
      next_mask = mask;
      clrBits = SRC_RST;
      unique case (state)
         ST_IDLE: begin
            if (avs_read || avs_write) begin
               next_state = ST_ACK;
               next_waitReq = 1'b0;
               if (avs_read) begin
                  next_readData = readValue;
               end
               // Only bits software has seen may be cleared
               if (avs_read && avs_address == OFS_FLAG) begin
                  next_captured = flags;
               end else begin
                  next_captured = SRC_RST;
               end
            end
         end
         ST_ACK: begin
            next_state = ST_IDLE;
            if (avs_read) begin
               clrBits = captured;
            end
            if (avs_write) begin
               unique case (avs_address)
                  OFS_EN2: next_en2 = REG_W'(wrWord({16'h0000, en2},
                     avs_writedata, avs_byteenable, EN2_IMPL));
                  OFS_EN3: next_en3 = REG_W'(wrWord({16'h0000, en3},
                     avs_writedata, avs_byteenable, EN3_IMPL));
                  OFS_EN4: next_en4 = REG_W'(wrWord({16'h0000, en4},
                     avs_writedata, avs_byteenable, EN4_IMPL));
                  OFS_EN5: next_en5 = REG_W'(wrWord({16'h0000, en5},
                     avs_writedata, avs_byteenable, EN5_IMPL));
                  OFS_PRIO0: next_prio0 = REG_W'(wrWord({16'h0000, prio0},
                     avs_writedata, avs_byteenable,
                     PRIO0_IMPL));
                  OFS_PRIO1: next_prio1 = REG_W'(wrWord({16'h0000, prio1},
                     avs_writedata, avs_byteenable,
                     PRIO1_IMPL));
                  OFS_MASK: next_mask = NUM_SRC'(wrWord({13'h0000, mask},
                     avs_writedata, avs_byteenable,
                     SRC_IMPL));
                  default: begin
                  end
               endcase
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // A request in the clearing cycle survives
      next_flags = (flags & ~clrBits) | srcReq;
   end

   // Per-source enable and level, then gating
   always_comb begin
      srcEnable[NUM_PRIO_SRC-1:0] = lowEnable;
      srcEnable[7] = en2[CAP3_EN_BIT];
      srcEnable[8] = en2[SPI2_EVT_EN_BIT];
      srcEnable[9] = en2[SPI2_FLT_EN_BIT];
      srcEnable[10] = en3[CAL_EN_BIT];
      srcEnable[11] = en3[TW2_MST_EN_BIT];
      srcEnable[12] = en3[TW2_SLV_EN_BIT];
      srcEnable[13] = en4[CTIME_EN_BIT];
      srcEnable[14] = en4[VDET_EN_BIT];
      srcEnable[15] = en4[CRC_EN_BIT];
      srcEnable[16] = en4[SER2_ERR_EN_BIT];
      srcEnable[17] = en4[SER1_ERR_EN_BIT];
      srcEnable[18] = en5[WAKE_EN_BIT];
      srcPrio[0] = field(prio0, EXT_PRIO_LSB);
      srcPrio[1] = field(prio0, CAPTURE_PRIO_LSB);
      srcPrio[2] = field(prio0, COMPARE_PRIO_LSB);
      srcPrio[3] = field(prio0, TIMER_PRIO_LSB);
      srcPrio[4] = field(prio1, CAPTURE_PRIO_LSB);
      srcPrio[5] = field(prio1, COMPARE_PRIO_LSB);
      srcPrio[6] = field(prio1, TIMER_PRIO_LSB);
      srcPrio[NUM_SRC-1:NUM_PRIO_SRC] = extPrio;
      for (int i = 0; i < NUM_SRC; i++) begin
         // Level 0 never forwards; 1..7 pass straight through
         next_fwd[i].valid = flags[i] && srcEnable[i]
            && (srcPrio[i] != 3'h0);
         next_fwd[i].level = next_fwd[i].valid ? srcPrio[i]
            : 3'h0;
      end
      next_irq = |(flags & mask);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         captured <= SRC_RST;
         en2 <= EN_RST;
         en3 <= EN_RST;
         en4 <= EN_RST;
         en5 <= EN_RST;
         prio0 <= PRIO0_RST;
         prio1 <= PRIO1_RST;
         flags <= SRC_RST;
         mask <= SRC_RST;
         fwdOut <= '0;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         avs_waitrequest <= next_waitReq;
         avs_readdata <= next_readData;
         captured <= next_captured;
         en2 <= next_en2;
         en3 <= next_en3;
         en4 <= next_en4;
         en5 <= next_en5;
         prio0 <= next_prio0;
         prio1 <= next_prio1;
         flags <= next_flags;
         mask <= next_mask;
         fwdOut <= next_fwd;
         irq <= next_irq;
      end
   end
endmodule

// ---- tb/irq_regs_asserts.sv ----
// Checker for the enable/priority slice, on the top-level ports only.
// Assumes one sys_clk domain with synchronous active-high sys_rst.
`timescale 1ns/1ns
module irq_regs_asserts (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bus
   input wire logic [irq_regs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [irq_regs_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Sources and outputs
   input wire irq_regs_pkg::src_vec_t srcReq,
   input wire irq_regs_pkg::low_en_t lowEnable,
   input wire irq_regs_pkg::ext_prio_t extPrio,
   input wire irq_regs_pkg::fwd_vec_t fwdOut,
   input wire logic irq
);
   import irq_regs_pkg::*;
   low_en_t lowEnQ;
   ext_prio_t extPrioQ;
   logic fwdBad;
   logic gateBad;
   // Inputs as the forwarding stage used them
   always_ff @(posedge sys_clk) begin
      lowEnQ <= lowEnable;
      extPrioQ <= extPrio;
   end
   always_comb begin
      fwdBad = 1'b0;
      gateBad = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         fwdBad |= fwdOut[i].valid != (fwdOut[i].level != 3'h0);
         if (i < NUM_PRIO_SRC)
            gateBad |= fwdOut[i].valid & ~lowEnQ[i];
         else
            gateBad |= fwdOut[i].valid &
               (fwdOut[i].level != extPrioQ[i-NUM_PRIO_SRC]);
      end
   end
   function automatic logic [DATA_W-1:0] implOf(logic [ADDR_W-1:0] a);
      case (a)
         OFS_EN2: return EN2_IMPL;
         OFS_EN3: return EN3_IMPL;
         OFS_EN4: return EN4_IMPL;
         OFS_EN5: return EN5_IMPL;
         OFS_PRIO0: return PRIO0_IMPL;
         OFS_PRIO1: return PRIO1_IMPL;
         OFS_FLAG, OFS_MASK: return SRC_IMPL;
         default: return '0;
      endcase
   endfunction
   sequence taken_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence ack_s;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_ACK_AFTER_TAKE: assert property (taken_s |=> ack_s)
      else $error("request not answered after one wait cycle");
   AST_IDLE_WAIT: assert property (!(avs_read || avs_write) &&
      avs_waitrequest |=> avs_waitrequest)
      else $error("answer without a request");
   AST_READ_ZERO: assert property (avs_read && !avs_waitrequest |->
      (avs_readdata & ~implOf(avs_address)) == '0)
      else $error("unimplemented bits read nonzero");
   AST_RESET_STATE: assert property (disable iff (1'b0) sys_rst |=>
      avs_waitrequest && !irq && fwdOut == '0)
      else $error("outputs not in reset state");
   AST_FWD_FORM: assert property (!fwdBad)
      else $error("forward valid and level disagree");
   AST_LOW_GATE: assert property (!gateBad)
      else $error("forward ignores enable or level");
   AST_IRQ_CAUSE: assert property ($rose(irq) |->
      $past(|srcReq, 2) || $past(avs_write && !avs_waitrequest, 2))
      else $error("interrupt rose without a cause");
   AST_IRQ_STEADY: assert property (irq && !$past(avs_read)
      && !$past(avs_write) |=> irq)
      else $error("interrupt dropped without a bus access");
endmodule

// ---- tb/request_source_model.sv ----
// Peripheral request sources: each fire bit becomes a one-cycle request.
// Assumes fire is driven by the bench on sys_clk.
`timescale 1ns/1ns
module request_source_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Command and requests
   input wire irq_regs_pkg::src_vec_t fire,
   output irq_regs_pkg::src_vec_t srcReq
);
   import irq_regs_pkg::*;
   src_vec_t next_srcReq;
   // Event lasts one cycle, so only the sticky flag can keep it
   always_comb next_srcReq = sys_rst ? '0 : fire;
   always_ff @(posedge sys_clk) srcReq <= next_srcReq;
endmodule

// ---- tb/interrupt_enable_priority_regs_test.sv ----
// Bench: register map, request gating, ranking and summary interrupt.
// Assumes the package map and a one-wait-cycle Avalon-MM slave.
`timescale 1ns/1ns
module interrupt_enable_priority_regs_test;
   import irq_regs_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   src_vec_t fire = '0;
   src_vec_t srcReq;
   low_en_t lowEnable = '1;
   ext_prio_t extPrio = {NUM_EN_SRC{3'h5}};
   fwd_vec_t fwdOut;
   logic irq;
   logic [DATA_W-1:0] rd;
   int err_count = 0;
   int checks = 0;
   logic [DATA_W-1:0] implTab [6] = '{EN2_IMPL, EN3_IMPL, EN4_IMPL,
      EN5_IMPL, PRIO0_IMPL, PRIO1_IMPL};
   logic [DATA_W-1:0] rstTab [6] = '{32'(EN_RST), 32'(EN_RST),
      32'(EN_RST), 32'(EN_RST), 32'(PRIO0_RST), 32'(PRIO1_RST)};
   logic [DATA_W-1:0] fwdTab [4] = '{0, 32'h9, 32'hB, 32'hF};
   int enReg [12] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 3};
   int enBit [12] = '{5, 1, 0, 14, 2, 1, 13, 8, 3, 2, 1, 0};
   interrupt_enable_priority_regs DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .srcReq(srcReq), .lowEnable(lowEnable), .extPrio(extPrio),
      .fwdOut(fwdOut), .irq(irq));
   request_source_model srcModel (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .fire(fire), .srcReq(srcReq));
   task automatic conclude();
      if (err_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] got, exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Request held until the rising edge that sees waitrequest low
   task automatic bus(input logic wr, input int a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      avs_address <= ADDR_W'(a);
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         check(1'b1, 1'b0);
         conclude();
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic pulse(input src_vec_t m);
      @(posedge sys_clk);
      fire <= m;
      @(posedge sys_clk);
      fire <= '0;
      settle();
   endtask
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, i, '0);
         check(rd, rstTab[i]);
         bus(1'b1, i, '1);
         bus(1'b0, i, '0);
         check(rd, implTab[i]);
         bus(1'b1, i, '0);
         bus(1'b0, i, '0);
         check(rd, '0);
      end
      bus(1'b1, 9, '1);
      bus(1'b0, 9, '0);
      check(rd, '0);
      for (int k = 0; k < NUM_EN_SRC; k++) begin
         bus(1'b1, enReg[k], 32'h1 << enBit[k]);
         pulse(src_vec_t'(1) << (k + NUM_PRIO_SRC));
         check(32'(fwdOut[k + NUM_PRIO_SRC]), 32'hD);
         bus(1'b1, enReg[k], '0);
         bus(1'b0, OFS_FLAG, '0);
         check(rd, 32'h1 << (k + NUM_PRIO_SRC));
      end
      bus(1'b1, OFS_PRIO0, 32'h7310);
      pulse(19'h0000F);
      for (int i = 0; i < 4; i++)
         check(32'(fwdOut[i]), fwdTab[i]);
      check(irq, 1'b0);
      @(posedge sys_clk);
      lowEnable <= 7'h77;
      settle();
      check(32'(fwdOut[3]), '0);
      bus(1'b1, OFS_MASK, 32'h8);
      settle();
      check(irq, 1'b1);
      bus(1'b0, OFS_FLAG, '0);
      check(rd, 32'hF);
      settle();
      check(irq, 1'b0);
      check(32'(fwdOut[2]), '0);
      conclude();
   end
endmodule
bind interrupt_enable_priority_regs irq_regs_asserts chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .srcReq(srcReq), .lowEnable(lowEnable), .extPrio(extPrio),
   .fwdOut(fwdOut), .irq(irq));
